// >>> inc/drt_regs.svh
// register offsets, field positions and timing counts of the dual reload timer
// Overview of operation
// - two independent 64-bit down-counters with initial values
// - initial value read/write, running value read-only
// - run-enable bits in control, cleared at reset
// - enable copies initial value, then decrements each clock
// - reaching zero raises high and low expiry
// - expiry reloads initial value, keeps counting periodically
// - writing 1 to initial value ignored while running
// - other initial writes take effect at next reload
// - timer 0 expiry drives four-cycle output pulse
// - expiry sets both latch bits of that timer
// - servicing clears only the serviced latch bit
`ifndef DRT_REGS_SVH
`define DRT_REGS_SVH
`define DRT_OFS_INIT0_LO 12'h000
`define DRT_OFS_INIT0_HI 12'h004
`define DRT_OFS_INIT1_LO 12'h008
`define DRT_OFS_INIT1_HI 12'h00C
`define DRT_OFS_RUN0_LO 12'h010
`define DRT_OFS_RUN0_HI 12'h014
`define DRT_OFS_RUN1_LO 12'h018
`define DRT_OFS_RUN1_HI 12'h01C
`define DRT_OFS_CTRL 12'h020
`define DRT_OFS_LATCH 12'h024
`define DRT_OFS_LATCH_CLR 12'h028
`define DRT_CTRL_RUN0_BIT 0
`define DRT_CTRL_RUN1_BIT 1
`define DRT_INIT_RESET 64'h0000_0000_0000_0000
`define DRT_IGNORED_INIT 64'h0000_0000_0000_0001
`define DRT_PULSE_CYCLES 3'h4
`endif

// >>> inc/drt_pkg.sv
// types shared by the dual reload timer
package drt_pkg;
  typedef logic [63:0] drt_count_t;
  typedef logic [31:0] drt_word_t;
  typedef enum logic [1:0] {DRT_LOW_T0, DRT_LOW_T1, DRT_HIGH_T0, DRT_HIGH_T1} drt_latch_e;
endpackage : drt_pkg

// >>> hdl/drt_timer.sv
// dual 64-bit reload timer with an AHB-Lite register slave
`include "drt_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module drt_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output drt_pkg::drt_word_t hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [3:0] interrupt_latch_o,
  output logic timer0_expire_out_o
);
  import drt_pkg::*;

  // register bank state: two 64-bit initial values and two 64-bit counters
  drt_count_t init_reg [2];
  drt_count_t init_next [2];
  drt_count_t cnt_reg [2];
  drt_count_t cnt_next [2];
  logic [1:0] run_reg, run_next;
  logic [3:0] latch_reg, latch_next;
  logic [2:0] pulse_reg, pulse_next;
  logic pin_reg, pin_next;
  drt_word_t rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [11:0] wr_addr_reg, wr_addr_next;
  logic [1:0] expire;
  logic [1:0] run_prev_reg;

  // decode one word offset into a read value
  function automatic drt_word_t read_word(input logic [11:0] a, input drt_count_t i0, input drt_count_t i1,
      input drt_count_t c0, input drt_count_t c1, input logic [1:0] r, input logic [3:0] l);
    unique case (a)
      `DRT_OFS_INIT0_LO: read_word = i0[31:0];
      `DRT_OFS_INIT0_HI: read_word = i0[63:32];
      `DRT_OFS_INIT1_LO: read_word = i1[31:0];
      `DRT_OFS_INIT1_HI: read_word = i1[63:32];
      `DRT_OFS_RUN0_LO: read_word = c0[31:0];
      `DRT_OFS_RUN0_HI: read_word = c0[63:32];
      `DRT_OFS_RUN1_LO: read_word = c1[31:0];
      `DRT_OFS_RUN1_HI: read_word = c1[63:32];
      `DRT_OFS_CTRL: read_word = {30'h0, r};
      `DRT_OFS_LATCH: read_word = {28'h000_0000, l};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // one-shot activity per timer: enable edge loads, zero expires
  generate
    for (genvar t = 0; t < 2; t++) begin : g_exp
      assign expire[t] = run_reg[t] && run_prev_reg[t] && (cnt_reg[t] == 64'h0000_0000_0000_0000);
    end
  endgenerate

  // address phase accepted on a write; data arrives the cycle after
  logic take_wr, take_rd;
  assign take_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i && (hsize_i == 3'h2);
  assign take_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;

  // next-state for registers, counters, latches and pulse
  always_comb begin
    drt_count_t nv;
    logic [1:0] hw;
    nv = '0;
    hw = 2'h0;
    init_next = init_reg;
    run_next = run_reg;
    latch_next = latch_reg;
    wr_pend_next = take_wr;
    wr_addr_next = haddr_i;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `DRT_OFS_INIT0_LO, `DRT_OFS_INIT1_LO: begin
          hw = (wr_addr_reg == `DRT_OFS_INIT1_LO) ? 2'h1 : 2'h0;
          nv = {init_reg[hw[0]][63:32], hwdata_i};
        end
        `DRT_OFS_INIT0_HI, `DRT_OFS_INIT1_HI: begin
          hw = (wr_addr_reg == `DRT_OFS_INIT1_HI) ? 2'h1 : 2'h0;
          nv = {hwdata_i, init_reg[hw[0]][31:0]};
        end
        `DRT_OFS_CTRL: run_next = hwdata_i[1:0];
        `DRT_OFS_LATCH_CLR: latch_next = latch_reg & ~hwdata_i[3:0];
        default: ; // running value and unmapped writes dropped
      endcase
      if (wr_addr_reg inside {`DRT_OFS_INIT0_LO, `DRT_OFS_INIT0_HI, `DRT_OFS_INIT1_LO, `DRT_OFS_INIT1_HI}) begin
        if (!(run_reg[hw[0]] && nv == `DRT_IGNORED_INIT))
          init_next[hw[0]] = nv;
      end
    end
    // counters: load on enable edge, reload on expiry, else decrement
    for (int t = 0; t < 2; t++) begin
      if (!run_reg[t])
        cnt_next[t] = cnt_reg[t];
      else if (!run_prev_reg[t] || expire[t])
        cnt_next[t] = init_reg[t];
      else
        cnt_next[t] = cnt_reg[t] - 64'h0000_0000_0000_0001;
    end
    // hardware set wins over software clear
    latch_next = latch_next | {expire, expire};
    // timer 0 pulse stretcher, retriggered by a fresh expiry
    if (expire[0])
      pulse_next = `DRT_PULSE_CYCLES;
    else if (pulse_reg != 3'h0)
      pulse_next = pulse_reg - 3'h1;
    else
      pulse_next = 3'h0;
    pin_next = (pulse_next != 3'h0);
    // read from next values so a read right behind a write sees that write
    rdata_next = take_rd ? read_word(haddr_i, init_next[0], init_next[1], cnt_next[0], cnt_next[1],
                                     run_next, latch_next) : rdata_reg;
  end

  // registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_reg[0] <= `DRT_INIT_RESET;
      init_reg[1] <= `DRT_INIT_RESET;
      cnt_reg[0] <= `DRT_INIT_RESET;
      cnt_reg[1] <= `DRT_INIT_RESET;
      run_reg <= 2'h0;
      run_prev_reg <= 2'h0;
      latch_reg <= 4'h0;
      pulse_reg <= 3'h0;
      pin_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      init_reg <= init_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      run_prev_reg <= run_reg;
      latch_reg <= latch_next;
      pulse_reg <= pulse_next;
      pin_reg <= pin_next;
      rdata_reg <= rdata_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  assign interrupt_latch_o = latch_reg;
  assign timer0_expire_out_o = pin_reg;
endmodule : drt_timer
`default_nettype wire

// >>> testbench/drt_timer_assertions.sv
// port-level timing checks of the dual reload timer
`timescale 1ns/10ps
`default_nettype none
module drt_timer_assertions
  import drt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire drt_word_t hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [3:0] interrupt_latch_o,
  input wire logic timer0_expire_out_o
);
  wire logic p = timer0_expire_out_o;
  wire logic [3:0] l = interrupt_latch_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ready_okay_a: assert property (hreadyout_o && !hresp_o) else $error("stall or error");
  read_hold_a: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved");
  pulse_len_a: assert property ($rose(p) |-> p[*4] ##1 !p) else $error("pulse length");
  pulse_cause_a: assert property ($rose(p) |-> ##[0:1] (l[0] && l[2])) else $error("pulse without latch");
  pair_low0_a: assert property ($rose(l[0]) |-> l[2]) else $error("t0 low alone");
  pair_high0_a: assert property ($rose(l[2]) |-> l[0]) else $error("t0 high alone");
  pair_low1_a: assert property ($rose(l[1]) |-> l[3]) else $error("t1 low alone");
  pair_high1_a: assert property ($rose(l[3]) |-> l[1]) else $error("t1 high alone");
endmodule : drt_timer_assertions
`default_nettype wire

// >>> testbench/drt_core_model.sv
// core side model that counts timer 0 expiry pulses
`timescale 1ns/10ps
`default_nettype none
module drt_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic timer0_expire_out_o,
  output int t0_expiries_o
);
  logic prev_reg;
  // a rising edge is one expiry; a held pulse counts once
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b0;
      t0_expiries_o <= 0;
    end else begin
      prev_reg <= timer0_expire_out_o;
      if (timer0_expire_out_o && !prev_reg) t0_expiries_o <= t0_expiries_o + 1;
    end
  end
endmodule : drt_core_model
`default_nettype wire

// >>> testbench/drt_timer_bench.sv
// register-level bench of the dual reload timer
`include "drt_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module drt_timer_bench;
  import drt_pkg::*;
  logic clk_i, rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, timer0_expire_out_o;
  logic [11:0] haddr_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [3:0] interrupt_latch_o;
  drt_word_t hwdata_i, hrdata_o, q;
  wire logic hready_i = hreadyout_o;
  int t0_expiries_o, failures, comparisons;
  int cyc = 0;
  drt_timer drt_timer_inst (.*);
  drt_core_model drt_core_model_inst (.*);
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task chk(input drt_word_t g, input drt_word_t e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // single word transfer, held until hready is seen high
  task xfer(input logic w, input logic [11:0] a, input drt_word_t d);
    hsel_i <= 1'b1; htrans_i <= 2'h2; haddr_i <= a; hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0; hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask : xfer
  task rd(input logic [11:0] a, input drt_word_t e);
    xfer(1'b0, a, 32'h0); chk(q, e);
  endtask : rd
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard: the sequence needs roughly 120 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end
  initial begin
    {rstn_i, hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i} = '0;
    hsize_i = 3'h2;
    fork
    begin : tests
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`DRT_OFS_CTRL, 32'h0);
    xfer(1'b1, `DRT_OFS_INIT0_LO, 32'h9);
    xfer(1'b1, `DRT_OFS_INIT1_LO, 32'h7);
    xfer(1'b1, `DRT_OFS_RUN0_LO, 32'h5);
    rd(`DRT_OFS_RUN0_LO, 32'h0);
    rd(`DRT_OFS_INIT0_LO, 32'h9);
    rd(`DRT_OFS_LATCH, 32'h0);
    xfer(1'b1, `DRT_OFS_CTRL, 32'h3);
    xfer(1'b1, `DRT_OFS_INIT0_LO, 32'h1);
    rd(`DRT_OFS_INIT0_LO, 32'h9);
    xfer(1'b1, `DRT_OFS_INIT0_LO, 32'h13);
    xfer(1'b0, `DRT_OFS_RUN0_LO, 32'h0);
    chk({31'h0, q < 32'hA}, 32'h1);
    repeat (60) @(posedge clk_i);
    xfer(1'b1, `DRT_OFS_CTRL, 32'h0);
    xfer(1'b0, `DRT_OFS_RUN0_LO, 32'h0);
    repeat (5) @(posedge clk_i);
    rd(`DRT_OFS_RUN0_LO, q);
    rd(`DRT_OFS_LATCH, 32'hF);
    xfer(1'b1, `DRT_OFS_LATCH_CLR, 32'h1);
    rd(`DRT_OFS_LATCH, 32'hE);
    chk({31'h0, t0_expiries_o > 2}, 32'h1);
    rd(12'h030, 32'h0);
    end
    begin : guard
      wait (cyc == 2000);
      failures++;
    end
    join_any
    disable fork;
    complete_run;
  end
endmodule : drt_timer_bench
bind drt_timer drt_timer_assertions drt_timer_assertions_inst (.*);
`default_nettype wire
